// *** dv/fps_props.sv ***
// Checker for the fan cutoff and source binding block.
module fps_props
  import fps_pkg::*;
#(parameter int DUTY_W = 9, parameter int TEMP_W = 16) (
  // Clock, reset and register access
  input wire logic core_clk, resetn, reg_wr,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  // Duty path
  input wire logic [FPS_COEF_W-1:0] chan_a_smoothing_coef, chan_b_smoothing_coef,
  input wire logic [DUTY_W-1:0] chan_a_filt_duty, chan_b_filt_duty, loop_duty,
  input wire logic [DUTY_W-1:0] chan_a_duty, chan_b_duty,
  // Temperature routing
  input wire logic [TEMP_W-1:0] zone1_temp, zone2_temp, zone3_temp, zone4_temp, loop_temp,
  input wire logic [TEMP_W-1:0] table1_temp, table2_temp, table3_temp, table4_temp,
  input wire logic loop_temp_valid, zone1_loop_filtering, zone2_loop_filtering
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic [7:0] ca_ff, cb_ff, bd_ff;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ca_ff <= FPS_RST_CUTOFF;
      cb_ff <= FPS_RST_CUTOFF;
      bd_ff <= FPS_RST_BINDING;
    end else if (reg_wr) begin
      if (reg_addr == FPS_OFS_CUTOFF_A) ca_ff <= reg_wdata & 8'hf8;
      if (reg_addr == FPS_OFS_CUTOFF_B) cb_ff <= reg_wdata & 8'hf8;
      if (reg_addr == FPS_OFS_BINDING) bd_ff <= reg_wdata;
    end
  end
  // The first edge after reset still shows reset values, so checks wait one edge.
  logic live_ff;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      live_ff <= 1'b0;
    end else begin
      live_ff <= 1'b1;
    end
  end
  wire logic cut_a = chan_a_smoothing_coef != FPS_COEF_BYPASS && chan_a_filt_duty < ca_ff;
  wire logic cut_b = chan_b_smoothing_coef != FPS_COEF_BYPASS && chan_b_filt_duty < cb_ff;
  wire logic hot1 = $signed(zone1_temp) >= $signed(zone2_temp);
  wire logic [TEMP_W-1:0] lt_exp = bd_ff[1:0] == 2'h3 ? (hot1 ? zone1_temp : zone2_temp) :
    bd_ff[0] ? zone1_temp : bd_ff[1] ? zone2_temp : '0;
  wire logic [7:0] rd_exp = reg_addr == 8'h33 ? ca_ff : reg_addr == 8'h34 ? cb_ff :
    reg_addr == 8'h35 ? bd_ff : 8'h00;
  chk_cut_a_gate: assert property (live_ff && !$past(bd_ff[2]) |->
    chan_a_duty == ($past(cut_a) ? '0 : $past(chan_a_filt_duty)))
    else $error("chan_a_duty cutoff wrong");
  chk_cut_b_gate: assert property (live_ff && !$past(bd_ff[3]) |->
    chan_b_duty == ($past(cut_b) ? '0 : $past(chan_b_filt_duty)))
    else $error("chan_b_duty cutoff wrong");
  chk_loop_a_path: assert property (live_ff && $past(bd_ff[2]) |->
    chan_a_duty == $past(loop_duty)) else $error("chan_a_duty not from loop");
  chk_loop_b_path: assert property (live_ff && $past(bd_ff[3]) |->
    chan_b_duty == $past(loop_duty)) else $error("chan_b_duty not from loop");
  chk_table_route: assert property (live_ff |->
    {table4_temp, table3_temp, table2_temp, table1_temp} ==
    $past({bd_ff[7] ? zone2_temp : zone4_temp, bd_ff[6] ? zone1_temp : zone3_temp,
    bd_ff[5] ? zone2_temp : zone4_temp, bd_ff[4] ? zone1_temp : zone3_temp}))
    else $error("table input wrong");
  chk_loop_source: assert property (live_ff |-> loop_temp == $past(lt_exp) &&
    loop_temp_valid == $past(|bd_ff[1:0])) else $error("loop_temp wrong");
  chk_loop_filter: assert property (live_ff |->
    {zone2_loop_filtering, zone1_loop_filtering} == $past(bd_ff[1:0]))
    else $error("loop filtering flags wrong");
  chk_read_back: assert property (live_ff && !$past(reg_wr) |->
    reg_rdata == $past(rd_exp)) else $error("reg_rdata wrong");
  cover property ($past(cut_a) && !$past(bd_ff[2]));
  cover property ($past(bd_ff[1:0]) == 2'h3 && loop_temp_valid);
  cover property ($past(bd_ff[3]) && chan_b_duty != '0);
  cover property (live_ff && $past(chan_a_smoothing_coef) == FPS_COEF_BYPASS && chan_a_duty != '0);
endmodule // fps_props

bind fps_top fps_props #(.DUTY_W(DUTY_W), .TEMP_W(TEMP_W)) u_props (
  .core_clk(core_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .chan_a_smoothing_coef(chan_a_smoothing_coef),
  .chan_b_smoothing_coef(chan_b_smoothing_coef),
  .chan_a_filt_duty(chan_a_filt_duty), .chan_b_filt_duty(chan_b_filt_duty),
  .loop_duty(loop_duty), .chan_a_duty(chan_a_duty), .chan_b_duty(chan_b_duty),
  .zone1_temp(zone1_temp), .zone2_temp(zone2_temp), .zone3_temp(zone3_temp),
  .zone4_temp(zone4_temp), .loop_temp(loop_temp),
  .table1_temp(table1_temp), .table2_temp(table2_temp), .table3_temp(table3_temp),
  .table4_temp(table4_temp), .loop_temp_valid(loop_temp_valid),
  .zone1_loop_filtering(zone1_loop_filtering), .zone2_loop_filtering(zone2_loop_filtering)
);

// *** dv/testbench.sv ***
// Self-checking testbench for the fan cutoff and source binding block.
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module testbench;
  import fps_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] addr, wd, rd;
    logic [2:0] coef;
    logic [8:0] filt, lp, ea, eb;
  } fps_row_s;
  fps_row_s rows [8] = '{'{8'h33, 8'hff, 8'hf8, 3'h1, 9'h0f7, 9'h000, 9'h000, 9'h0f7},
    '{8'h34, 8'h0f, 8'h08, 3'h1, 9'h007, 9'h000, 9'h000, 9'h000},
    '{8'h34, 8'h0f, 8'h08, 3'h1, 9'h008, 9'h000, 9'h000, 9'h008},
    '{8'h33, 8'h17, 8'h10, 3'h1, 9'h00f, 9'h000, 9'h000, 9'h00f},
    '{8'h33, 8'h17, 8'h10, 3'h0, 9'h005, 9'h000, 9'h005, 9'h005},
    '{8'h35, 8'h0c, 8'h0c, 3'h1, 9'h003, 9'h1a5, 9'h1a5, 9'h1a5},
    '{8'h36, 8'hab, 8'h00, 3'h1, 9'h003, 9'h1a5, 9'h1a5, 9'h1a5},
    '{8'h35, 8'h00, 8'h00, 3'h1, 9'h010, 9'h000, 9'h010, 9'h010}};
  int n_mismatch = 0, cmp_count = 0;
  logic core_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [2:0] chan_a_smoothing_coef = 3'h0, chan_b_smoothing_coef = 3'h0;
  logic [8:0] chan_a_filt_duty = '0, chan_b_filt_duty = '0, loop_duty = '0;
  logic [8:0] chan_a_duty, chan_b_duty;
  logic [15:0] zone1_temp = 16'hfffb, zone2_temp = 16'h0003;
  logic [15:0] zone3_temp = 16'h0101, zone4_temp = 16'h0202, loop_temp;
  logic [15:0] table1_temp, table2_temp, table3_temp, table4_temp;
  logic loop_temp_valid, zone1_loop_filtering, zone2_loop_filtering;
  wire logic [63:0] tbls = {table4_temp, table3_temp, table2_temp, table1_temp};
  wire logic [63:0] zs = {zone4_temp, zone3_temp, zone2_temp, zone1_temp};
  fps_top dut (
    .core_clk(core_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .chan_a_smoothing_coef(chan_a_smoothing_coef),
    .chan_b_smoothing_coef(chan_b_smoothing_coef),
    .chan_a_filt_duty(chan_a_filt_duty), .chan_b_filt_duty(chan_b_filt_duty),
    .loop_duty(loop_duty),
    .zone1_temp(zone1_temp), .zone2_temp(zone2_temp), .zone3_temp(zone3_temp),
    .zone4_temp(zone4_temp),
    .chan_a_duty(chan_a_duty), .chan_b_duty(chan_b_duty),
    .loop_temp(loop_temp), .loop_temp_valid(loop_temp_valid),
    .zone1_loop_filtering(zone1_loop_filtering), .zone2_loop_filtering(zone2_loop_filtering),
    .table1_temp(table1_temp), .table2_temp(table2_temp), .table3_temp(table3_temp),
    .table4_temp(table4_temp)
  );
  initial forever #5 core_clk = ~core_clk;
  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk);
    reg_addr = a;
    @(negedge core_clk);
    `CHK("reg_rdata", e, reg_rdata)
  endtask
  initial begin
    #5us;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(negedge core_clk);
    resetn = 1'b1;
    foreach (rows[i]) begin
      chan_a_smoothing_coef = rows[i].coef;
      chan_b_smoothing_coef = rows[i].coef;
      chan_a_filt_duty = rows[i].filt;
      chan_b_filt_duty = rows[i].filt;
      loop_duty = rows[i].lp;
      wr(rows[i].addr, rows[i].wd);
      `CHK("reg_rdata", rows[i].rd, reg_rdata)
      `CHK("chan_a_duty", rows[i].ea, chan_a_duty)
      `CHK("chan_b_duty", rows[i].eb, chan_b_duty)
    end
    resetn = 1'b0;
    repeat (20) @(negedge core_clk);
    resetn = 1'b1;
    rd_chk(8'h33, 8'h00);
    rd_chk(8'h34, 8'h00);
    rd_chk(8'h35, 8'h30);
    `CHK("tables", zs, tbls)
    `CHK("loop_temp_valid", 1'b0, loop_temp_valid)
    wr(8'h35, 8'hc3);
    `CHK("tables", {zs[31:0], zs[63:32]}, tbls)
    `CHK("loop_temp", zone2_temp, loop_temp)
    `CHK("loop_filtering", 2'h3, {zone2_loop_filtering, zone1_loop_filtering})
    wr(8'h35, 8'h01);
    `CHK("loop_temp", zone1_temp, loop_temp)
    wr(8'h35, 8'h02);
    `CHK("loop_temp", zone2_temp, loop_temp)
    report_and_stop();
  end
endmodule // testbench

// *** rtl/fps_cutoff.sv ***
// One PWM channel's low duty cutoff: threshold forming and output forcing.
module fps_cutoff
  import fps_pkg::*;
#(
  parameter int DUTY_W = 9
) (
  // Settings
  input wire logic [FPS_CUTOFF_W-1:0] cutoff_level,
  input wire logic [FPS_COEF_W-1:0] smoothing_coef,
  // Duty path
  input wire logic [DUTY_W-1:0] filt_duty,
  output logic [DUTY_W-1:0] cut_duty
);

  if (DUTY_W < FPS_THR_W) begin : g_bad_duty_w
    $error("fps_cutoff: DUTY_W must be at least the threshold width");
  end

  // ==========================================================================
  // Threshold and forcing
  // ==========================================================================
  wire logic [DUTY_W-1:0] threshold;
  wire logic bypassed;
  wire logic below;

  assign threshold = DUTY_W'({cutoff_level, {FPS_THR_SHIFT{1'b0}}});
  assign bypassed = (smoothing_coef == FPS_COEF_BYPASS);
  assign below = (filt_duty < threshold);
  // Bypassed filter leaves the duty untouched.
  assign cut_duty = (below && !bypassed) ? '0 : filt_duty;

endmodule : fps_cutoff

// *** rtl/fps_pkg.sv ***
// Package with register map, reset values and field layouts of the fan shutoff and binding block.
package fps_pkg;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [7:0] FPS_OFS_COEF = 8'h32;
  localparam logic [7:0] FPS_OFS_CUTOFF_A = 8'h33;
  localparam logic [7:0] FPS_OFS_CUTOFF_B = 8'h34;
  localparam logic [7:0] FPS_OFS_BINDING = 8'h35;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] FPS_RST_CUTOFF = 8'h00;
  localparam logic [7:0] FPS_RST_BINDING = 8'h30;

  // ==========================================================================
  // Field layout
  // ==========================================================================
  localparam int FPS_CUTOFF_LSB = 3;
  localparam int FPS_CUTOFF_W = 5;
  localparam int FPS_THR_SHIFT = 3;
  localparam int FPS_THR_W = 9;
  localparam int FPS_COEF_W = 3;
  localparam logic [2:0] FPS_COEF_BYPASS = 3'h0;

  typedef struct packed {
    logic table_four_cpu_zone_b;
    logic table_three_cpu_zone_a;
    logic table_two_cpu_zone_b;
    logic table_one_cpu_zone_a;
    logic chan_b_from_loop;
    logic chan_a_from_loop;
    logic loop_uses_cpu_zone_b;
    logic loop_uses_cpu_zone_a;
  } fps_binding_s;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fps_reg_req_s;

endpackage : fps_pkg

// *** rtl/fps_top.sv ***
// Fan PWM low duty cutoff and PI/table temperature source binding.

// Behaviour
// - Threshold equals cutoff field times eight
// - Duty below threshold forces PWM off
// - Bypassed filter ignores the cutoff threshold
// - Coefficient code zero bypasses filter and cutoff
// - Bit 0 binds zone 1 to loop
// - Bit 1 binds zone 2 to loop
// - Both bound: loop regulates hotter zone
// - Loop binding changes zone filtering options
// - Bit 2 drives PWM A from loop
// - Bit 3 drives PWM B from loop
// - Bit 4: table one zone 1, else 3
// - Bit 5: table two zone 2, else 4
// - Bit 6: table three zone 1, else 3
// - Bit 7: table four zone 2, else 4
module fps_top
  import fps_pkg::*;
#(
  parameter int DUTY_W = 9,
  parameter int TEMP_W = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Register access from the serial interface engine
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Filter coefficients held by the filter settings register
  input wire logic [FPS_COEF_W-1:0] chan_a_smoothing_coef,
  input wire logic [FPS_COEF_W-1:0] chan_b_smoothing_coef,
  // Duty sources
  input wire logic [DUTY_W-1:0] chan_a_filt_duty,
  input wire logic [DUTY_W-1:0] chan_b_filt_duty,
  input wire logic [DUTY_W-1:0] loop_duty,
  // Zone temperatures, signed
  input wire logic [TEMP_W-1:0] zone1_temp,
  input wire logic [TEMP_W-1:0] zone2_temp,
  input wire logic [TEMP_W-1:0] zone3_temp,
  input wire logic [TEMP_W-1:0] zone4_temp,
  // PWM duty outputs
  output logic [DUTY_W-1:0] chan_a_duty,
  output logic [DUTY_W-1:0] chan_b_duty,
  // Loop input
  output logic [TEMP_W-1:0] loop_temp,
  output logic loop_temp_valid,
  output logic zone1_loop_filtering,
  output logic zone2_loop_filtering,
  // Table inputs
  output logic [TEMP_W-1:0] table1_temp,
  output logic [TEMP_W-1:0] table2_temp,
  output logic [TEMP_W-1:0] table3_temp,
  output logic [TEMP_W-1:0] table4_temp
);

  // ==========================================================================
  // Parameter checks
  // ==========================================================================
  if (TEMP_W < 2) begin : g_bad_temp_w
    $error("fps_top: TEMP_W must be at least 2");
  end
  if (DUTY_W < FPS_THR_W) begin : g_bad_duty_w
    $error("fps_top: DUTY_W must be at least the threshold width");
  end

  // ==========================================================================
  // Register file
  // ==========================================================================
  fps_reg_req_s req;
  logic [FPS_CUTOFF_W-1:0] cutoff_a_ff;
  logic [FPS_CUTOFF_W-1:0] cutoff_b_ff;
  fps_binding_s binding_ff;
  logic [7:0] reg_rdata_ff;
  wire logic wr_cut_a;
  wire logic wr_cut_b;
  wire logic wr_bind;
  wire logic [FPS_CUTOFF_W-1:0] wr_cut_field;
  wire logic [7:0] nxt_rdata;

  assign req = '{wr: reg_wr, addr: reg_addr, wdata: reg_wdata};
  assign wr_cut_a = req.wr && (req.addr == FPS_OFS_CUTOFF_A);
  assign wr_cut_b = req.wr && (req.addr == FPS_OFS_CUTOFF_B);
  assign wr_bind = req.wr && (req.addr == FPS_OFS_BINDING);
  // Only the upper field is stored; low bits of a write are dropped.
  assign wr_cut_field = req.wdata[FPS_CUTOFF_LSB +: FPS_CUTOFF_W];

  function automatic logic [7:0] cutoff_view(input logic [FPS_CUTOFF_W-1:0] lvl);
    cutoff_view = {lvl, {FPS_CUTOFF_LSB{1'b0}}};
  endfunction

  // Unmapped offsets read zero so other blocks can be OR-ed in.
  assign nxt_rdata = (req.addr == FPS_OFS_CUTOFF_A) ? cutoff_view(cutoff_a_ff) :
                     (req.addr == FPS_OFS_CUTOFF_B) ? cutoff_view(cutoff_b_ff) :
                     (req.addr == FPS_OFS_BINDING) ? binding_ff : 8'h00;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cutoff_a_ff <= FPS_RST_CUTOFF[FPS_CUTOFF_LSB +: FPS_CUTOFF_W];
      cutoff_b_ff <= FPS_RST_CUTOFF[FPS_CUTOFF_LSB +: FPS_CUTOFF_W];
      binding_ff <= FPS_RST_BINDING;
      reg_rdata_ff <= 8'h00;
    end else begin
      if (wr_cut_a) cutoff_a_ff <= wr_cut_field;
      if (wr_cut_b) cutoff_b_ff <= wr_cut_field;
      if (wr_bind) binding_ff <= req.wdata;
      reg_rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = reg_rdata_ff;

  // ==========================================================================
  // PWM paths
  // ==========================================================================
  wire logic [DUTY_W-1:0] cut_a;
  wire logic [DUTY_W-1:0] cut_b;
  wire logic [DUTY_W-1:0] nxt_duty_a;
  wire logic [DUTY_W-1:0] nxt_duty_b;

  fps_cutoff #(.DUTY_W(DUTY_W)) u_cut_a (
    .cutoff_level(cutoff_a_ff),
    .smoothing_coef(chan_a_smoothing_coef),
    .filt_duty(chan_a_filt_duty),
    .cut_duty(cut_a)
  );

  fps_cutoff #(.DUTY_W(DUTY_W)) u_cut_b (
    .cutoff_level(cutoff_b_ff),
    .smoothing_coef(chan_b_smoothing_coef),
    .filt_duty(chan_b_filt_duty),
    .cut_duty(cut_b)
  );

  assign nxt_duty_a = binding_ff.chan_a_from_loop ? loop_duty : cut_a;
  assign nxt_duty_b = binding_ff.chan_b_from_loop ? loop_duty : cut_b;

  // ==========================================================================
  // Temperature routing
  // ==========================================================================
  function automatic logic [TEMP_W-1:0] hotter(input logic [TEMP_W-1:0] x,
                                               input logic [TEMP_W-1:0] y);
    hotter = ($signed(x) >= $signed(y)) ? x : y;
  endfunction

  function automatic logic [TEMP_W-1:0] pick_zone(input logic use_cpu,
                                                  input logic [TEMP_W-1:0] cpu_temp,
                                                  input logic [TEMP_W-1:0] other_temp);
    pick_zone = use_cpu ? cpu_temp : other_temp;
  endfunction

  wire logic use_z1;
  wire logic use_z2;
  wire logic [TEMP_W-1:0] nxt_loop_temp;
  wire logic nxt_loop_valid;
  wire logic [TEMP_W-1:0] nxt_table1;
  wire logic [TEMP_W-1:0] nxt_table2;
  wire logic [TEMP_W-1:0] nxt_table3;
  wire logic [TEMP_W-1:0] nxt_table4;

  assign use_z1 = binding_ff.loop_uses_cpu_zone_a;
  assign use_z2 = binding_ff.loop_uses_cpu_zone_b;
  assign nxt_loop_temp = (use_z1 && use_z2) ? hotter(zone1_temp, zone2_temp) :
                         use_z2 ? zone2_temp :
                         use_z1 ? zone1_temp : '0;
  assign nxt_loop_valid = use_z1 || use_z2;
  // Each table reads a processor zone when its bit is set, else a board zone.
  assign nxt_table1 = pick_zone(binding_ff.table_one_cpu_zone_a,
                                zone1_temp, zone3_temp);
  assign nxt_table2 = pick_zone(binding_ff.table_two_cpu_zone_b,
                                zone2_temp, zone4_temp);
  assign nxt_table3 = pick_zone(binding_ff.table_three_cpu_zone_a,
                                zone1_temp, zone3_temp);
  assign nxt_table4 = pick_zone(binding_ff.table_four_cpu_zone_b,
                                zone2_temp, zone4_temp);

  logic [DUTY_W-1:0] chan_a_duty_ff;
  logic [DUTY_W-1:0] chan_b_duty_ff;
  logic [TEMP_W-1:0] loop_temp_ff;
  logic loop_valid_ff;
  logic z1_filt_ff;
  logic z2_filt_ff;
  logic [TEMP_W-1:0] table1_ff;
  logic [TEMP_W-1:0] table2_ff;
  logic [TEMP_W-1:0] table3_ff;
  logic [TEMP_W-1:0] table4_ff;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      chan_a_duty_ff <= '0;
      chan_b_duty_ff <= '0;
      loop_temp_ff <= '0;
      loop_valid_ff <= 1'b0;
      z1_filt_ff <= 1'b0;
      z2_filt_ff <= 1'b0;
      table1_ff <= '0;
      table2_ff <= '0;
      table3_ff <= '0;
      table4_ff <= '0;
    end else begin
      chan_a_duty_ff <= nxt_duty_a;
      chan_b_duty_ff <= nxt_duty_b;
      loop_temp_ff <= nxt_loop_temp;
      loop_valid_ff <= nxt_loop_valid;
      z1_filt_ff <= use_z1;
      z2_filt_ff <= use_z2;
      table1_ff <= nxt_table1;
      table2_ff <= nxt_table2;
      table3_ff <= nxt_table3;
      table4_ff <= nxt_table4;
    end
  end

  assign chan_a_duty = chan_a_duty_ff;
  assign chan_b_duty = chan_b_duty_ff;
  assign loop_temp = loop_temp_ff;
  assign loop_temp_valid = loop_valid_ff;
  assign zone1_loop_filtering = z1_filt_ff;
  assign zone2_loop_filtering = z2_filt_ff;
  assign table1_temp = table1_ff;
  assign table2_temp = table2_ff;
  assign table3_temp = table3_ff;
  assign table4_temp = table4_ff;

endmodule : fps_top
